// ==== design/lrds_config_port.sv ====
// configuration-port register space for line-rate divider switching
//
// Contract
// [RULE1] controller drains traffic, retunes dividers and clocks, then resets the pll; the bench switch sequence never resets the pll
// [RULE2] controller may power down an unused direction during the switch
// [RULE3] divider fields change at run time only with the dynamic option built in
// [RULE4] controller programs channel pll calibration values before the switch
// [RULE5] port gives full read and write of common and channel spaces
// [RULE6] controller changes a field by read, modify, write
// [RULE7] both shared plls and the channel pll use the same out-divide encoding
// [RULE8] tx divider at 0070 bits 10:8, rx at 0063 bits 2:0, codes 0..5
// [RULE9] controller computes pll output from input, dividers, fraction and rate
// [RULE10] controller takes line rate as twice pll output over out divider
// [RULE11] fraction is sigma-delta data over two to its width, kept at one
// [RULE12] low-rate type has fraction one and clockout factor two
// [RULE13] controller keeps reference, feedback and clockout settings in range
// [RULE14] feedback field bits 7:0 at 0014/0094 holds value minus two
// [RULE15] reference field bits 11:7 at 0018/0098, code 16 is divide-by-1
// [RULE16] controller sets tx power field to 00 or 11
// [RULE17] controller pulses equalizer datapath reset after mode change
// [RULE18] controller issues one access at a time and waits for it
`include "lrds_defs.svh"

module lrds_config_port #(
  parameter bit DYNAMIC_RATE_EN = 1'b1,
  parameter bit HIGH_RATE_TYPE  = 1'b1,
  parameter int CFG_AW          = 8
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // configuration port
  input  wire logic                 cfg_en,
  input  wire logic                 cfg_we,
  input  wire lrds_pkg::lrds_space_t cfg_space,
  input  wire logic [CFG_AW-1:0]    cfg_addr,
  input  wire logic [15:0]          cfg_wdata,
  output logic      [15:0]          cfg_rdata,
  output logic                      cfg_ready,
  // decoded divider settings
  output logic      [5:0]           tx_output_divider,
  output logic      [5:0]           rx_output_divider,
  output logic      [8:0]           ring_pll0_feedback_divider,
  output logic      [8:0]           ring_pll1_feedback_divider,
  output logic      [2:0]           ring_pll0_reference_divider,
  output logic      [2:0]           ring_pll1_reference_divider,
  output logic      [1:0]           ring_pll0_clockout_rate,
  output logic      [1:0]           ring_pll1_clockout_rate,
  output logic                      divider_setting_error
);

  localparam int DEPTH = 1 << CFG_AW;

  // the offsets in use need at least eight address bits
  if (CFG_AW < `LRDS_CFG_AW_MIN)
  begin : g_aw_check
    $error("CFG_AW too small for the register map");
  end

  lrds_pkg::lrds_port_state_t state_reg;
  lrds_pkg::lrds_port_state_t state_next;
  logic [15:0] common_mem_reg [0:DEPTH-1];
  logic [15:0] chan_mem_reg   [0:DEPTH-1];
  logic [15:0] rdata_reg;

  lrds_fields_if fields ();

  // divider bits inside a word; the rest of each word is plain storage
  function automatic logic [15:0] divider_mask(input lrds_pkg::lrds_space_t sp,
                                               input logic [CFG_AW-1:0] a);
    logic [7:0] lo;
    lo = a[7:0];
    divider_mask = `LRDS_MASK_NONE;
    if (a[CFG_AW-1:0] == CFG_AW'(lo))
      if (sp == lrds_pkg::LRDS_SPACE_CHANNEL)
        case (lo)
          `LRDS_ADDR_TX_DIV: divider_mask = `LRDS_MASK_TX_DIV;
          `LRDS_ADDR_RX_DIV: divider_mask = `LRDS_MASK_RX_DIV;
          default:           divider_mask = `LRDS_MASK_NONE;
        endcase
      else
        case (lo)
          `LRDS_ADDR_PLL0_FB, `LRDS_ADDR_PLL1_FB:   divider_mask = `LRDS_MASK_FB;
          `LRDS_ADDR_PLL0_REF, `LRDS_ADDR_PLL1_REF: divider_mask = `LRDS_MASK_REF;
          `LRDS_ADDR_PLL0_CKO, `LRDS_ADDR_PLL1_CKO: divider_mask = `LRDS_MASK_CKO;
          default:                                  divider_mask = `LRDS_MASK_NONE;
        endcase
  endfunction

  // access decode; a request is taken only while idle
  wire logic        take       = cfg_en && (state_reg == lrds_pkg::LRDS_IDLE);
  wire logic        is_chan    = (cfg_space == lrds_pkg::LRDS_SPACE_CHANNEL);
  wire logic [15:0] old_word   = is_chan ? chan_mem_reg[cfg_addr] : common_mem_reg[cfg_addr];
  // [RULE3] freeze dividers when static
  wire logic [15:0] keep_mask  = DYNAMIC_RATE_EN ? `LRDS_MASK_NONE
                                                 : divider_mask(cfg_space, cfg_addr);
  wire logic [15:0] write_word = (old_word & keep_mask) | (cfg_wdata & ~keep_mask);
  wire logic        wr_common  = take && cfg_we && !is_chan;
  wire logic        wr_chan    = take && cfg_we && is_chan;

  // answer state: one access in flight, ready marks its completion
  always_comb
  begin
    case (state_reg)
      lrds_pkg::LRDS_IDLE:   state_next = cfg_en ? lrds_pkg::LRDS_ANSWER : lrds_pkg::LRDS_IDLE;
      lrds_pkg::LRDS_ANSWER: state_next = lrds_pkg::LRDS_IDLE;
      default:               state_next = lrds_pkg::LRDS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state_reg <= lrds_pkg::LRDS_IDLE;
    else
      state_reg <= state_next;
  end

  // common-block words, reset so every divider starts at a legal setting
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        common_mem_reg[i] <= `LRDS_RST_OTHER;
      common_mem_reg[`LRDS_ADDR_PLL0_FB]  <= `LRDS_RST_FB;
      common_mem_reg[`LRDS_ADDR_PLL1_FB]  <= `LRDS_RST_FB;
      common_mem_reg[`LRDS_ADDR_PLL0_REF] <= `LRDS_RST_REF;
      common_mem_reg[`LRDS_ADDR_PLL1_REF] <= `LRDS_RST_REF;
      common_mem_reg[`LRDS_ADDR_PLL0_CKO] <= `LRDS_RST_CKO;
      common_mem_reg[`LRDS_ADDR_PLL1_CKO] <= `LRDS_RST_CKO;
    end
    // [RULE5] common space write
    else if (wr_common)
      common_mem_reg[cfg_addr] <= write_word;
  end

  // per-channel words
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < DEPTH; i++)
        chan_mem_reg[i] <= `LRDS_RST_OTHER;
      chan_mem_reg[`LRDS_ADDR_TX_DIV] <= `LRDS_RST_OUT_DIV;
      chan_mem_reg[`LRDS_ADDR_RX_DIV] <= `LRDS_RST_OUT_DIV;
    end
    // [RULE5] channel space write
    else if (wr_chan)
      chan_mem_reg[cfg_addr] <= write_word;
  end

  // read data is captured on the taking edge and held until the next read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= 16'h0000;
    else if (take && !cfg_we)
      rdata_reg <= old_word;
  end

  assign cfg_rdata = rdata_reg;
  assign cfg_ready = (state_reg == lrds_pkg::LRDS_ANSWER);

  // [RULE8] field extraction, out dividers
  assign fields.tx_code   = chan_mem_reg[`LRDS_ADDR_TX_DIV][`LRDS_TX_DIV_HI:`LRDS_TX_DIV_LO];
  assign fields.rx_code   = chan_mem_reg[`LRDS_ADDR_RX_DIV][`LRDS_RX_DIV_HI:`LRDS_RX_DIV_LO];
  // [RULE14] feedback fields
  assign fields.fb0_code  = common_mem_reg[`LRDS_ADDR_PLL0_FB][`LRDS_FB_HI:`LRDS_FB_LO];
  assign fields.fb1_code  = common_mem_reg[`LRDS_ADDR_PLL1_FB][`LRDS_FB_HI:`LRDS_FB_LO];
  // [RULE15] reference fields
  assign fields.ref0_code = common_mem_reg[`LRDS_ADDR_PLL0_REF][`LRDS_REF_HI:`LRDS_REF_LO];
  assign fields.ref1_code = common_mem_reg[`LRDS_ADDR_PLL1_REF][`LRDS_REF_HI:`LRDS_REF_LO];
  assign fields.cko0_bit  = common_mem_reg[`LRDS_ADDR_PLL0_CKO][`LRDS_CKO_BIT];
  assign fields.cko1_bit  = common_mem_reg[`LRDS_ADDR_PLL1_CKO][`LRDS_CKO_BIT];

  // [RULE7] one decoder for every pll
  lrds_div_decode #(
    .HIGH_RATE_TYPE (HIGH_RATE_TYPE)
  ) u_decode (
    .clk     (clk),
    .reset_n (reset_n),
    .f       (fields.decoder)
  );

  // decoded settings, registered inside the decoder
  assign tx_output_divider           = fields.tx_ratio;
  assign rx_output_divider           = fields.rx_ratio;
  assign ring_pll0_feedback_divider  = fields.fb0_value;
  assign ring_pll1_feedback_divider  = fields.fb1_value;
  assign ring_pll0_reference_divider = fields.ref0_value;
  assign ring_pll1_reference_divider = fields.ref1_value;
  assign ring_pll0_clockout_rate     = fields.cko0_factor;
  assign ring_pll1_clockout_rate     = fields.cko1_factor;
  assign divider_setting_error       = fields.setting_error;

  property p_ready_next;
    @(posedge clk) disable iff (!reset_n)
    take |=> cfg_ready ##1 !cfg_ready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("access not answered in one cycle"); // [RULE5]

  property p_read_back;
    @(posedge clk) disable iff (!reset_n)
    (take && !cfg_we) |=> (cfg_rdata == $past(old_word));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data not the addressed word"); // [RULE5]

  property p_write_lands;
    @(posedge clk) disable iff (!reset_n)
    (wr_chan && DYNAMIC_RATE_EN && cfg_addr == CFG_AW'(8'h70))
      |=> ##1 (tx_output_divider == 6'(6'h01 << $past(cfg_wdata[10:8], 2))
               || $past(cfg_wdata[10:8], 2) > 3'h5);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("tx divider write not applied"); // [RULE8]

  property p_static_frozen;
    @(posedge clk) disable iff (!reset_n)
    (!DYNAMIC_RATE_EN && wr_common && cfg_addr == CFG_AW'(8'h14))
      |=> $stable(fields.fb0_code);
  endproperty
  a_static_frozen: assert property (p_static_frozen) else $error("divider changed while static"); // [RULE3]

endmodule

// ==== design/lrds_defs.svh ====
// constants for the line-rate divider register space
`ifndef LRDS_DEFS_SVH
`define LRDS_DEFS_SVH

// common-block word offsets
`define LRDS_ADDR_PLL0_WORD_A  8'h08
`define LRDS_ADDR_SHARED_A     8'h09
`define LRDS_ADDR_PLL0_CKO     8'h0E
`define LRDS_ADDR_PLL0_WORD_B  8'h10
`define LRDS_ADDR_PLL0_WORD_C  8'h11
`define LRDS_ADDR_PLL0_FB      8'h14
`define LRDS_ADDR_PLL0_REF     8'h18
`define LRDS_ADDR_PLL1_WORD_A  8'h88
`define LRDS_ADDR_SHARED_B     8'h89
`define LRDS_ADDR_PLL1_CKO     8'h8E
`define LRDS_ADDR_PLL1_WORD_B  8'h90
`define LRDS_ADDR_PLL1_WORD_C  8'h91
`define LRDS_ADDR_PLL1_FB      8'h94
`define LRDS_ADDR_PLL1_REF     8'h98

// per-channel word offsets
`define LRDS_ADDR_RX_DIV       8'h63
`define LRDS_ADDR_TX_DIV       8'h70

// field positions
`define LRDS_TX_DIV_HI         10
`define LRDS_TX_DIV_LO         8
`define LRDS_RX_DIV_HI         2
`define LRDS_RX_DIV_LO         0
`define LRDS_FB_HI             7
`define LRDS_FB_LO             0
`define LRDS_REF_HI            11
`define LRDS_REF_LO            7
`define LRDS_CKO_BIT           0

// divider field masks, used to freeze them without the dynamic option
`define LRDS_MASK_FB           16'h00FF
`define LRDS_MASK_REF          16'h0F80
`define LRDS_MASK_CKO          16'h0001
`define LRDS_MASK_TX_DIV       16'h0700
`define LRDS_MASK_RX_DIV       16'h0007
`define LRDS_MASK_NONE         16'h0000

// reset values
`define LRDS_RST_FB            16'h000E
`define LRDS_RST_REF           16'h0800
`define LRDS_RST_CKO           16'h0001
`define LRDS_RST_OUT_DIV       16'h0000
`define LRDS_RST_OTHER         16'h0000

// encodings
`define LRDS_REF_CODE_DIV1     5'h10
`define LRDS_FB_OFFSET         9'h002
`define LRDS_FB_MIN            9'h010
`define LRDS_FB_MAX            9'h0A0
`define LRDS_OUT_CODE_MAX_HI   3'h5
`define LRDS_OUT_CODE_MAX_LO   3'h4
`define LRDS_CKO_FACTOR_FULL   2'h1
`define LRDS_CKO_FACTOR_HALF   2'h2
`define LRDS_CFG_AW_MIN        8

`endif

// ==== design/lrds_div_decode.sv ====
// decoder from stored divider codes to divide values
`include "lrds_defs.svh"

module lrds_div_decode #(
  parameter bit HIGH_RATE_TYPE = 1'b1
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // fields
  lrds_fields_if.decoder  f
);

  // output divider code to ratio, same table for every pll source
  function automatic logic [5:0] out_ratio(input logic [2:0] code);
    out_ratio = (code <= `LRDS_OUT_CODE_MAX_HI) ? 6'(6'h01 << code) : 6'h00;
  endfunction

  // reference divider code to value, zero marks an unused code
  function automatic logic [2:0] ref_value(input logic [4:0] code);
    case (code)
      `LRDS_REF_CODE_DIV1: ref_value = 3'h1;
      5'h00:               ref_value = 3'h2;
      5'h01:               ref_value = 3'h3;
      5'h02:               ref_value = 3'h4;
      default:             ref_value = 3'h0;
    endcase
  endfunction

  // feedback value legal for this transceiver type
  function automatic logic fb_ok(input logic [8:0] v);
    if (HIGH_RATE_TYPE)
      fb_ok = (v >= `LRDS_FB_MIN) && (v <= `LRDS_FB_MAX);
    else
      case (v)
        9'h010, 9'h014, 9'h020, 9'h028, 9'h03C, 9'h040, 9'h042, 9'h04B, 9'h050,
        9'h054, 9'h05A, 9'h060, 9'h064, 9'h070, 9'h078, 9'h07D, 9'h096: fb_ok = 1'b1;
        default: fb_ok = 1'b0;
      endcase
  endfunction

  // out-divide code legal for this type; divide-by-32 only on the high-rate type
  function automatic logic out_ok(input logic [2:0] code);
    out_ok = code <= (HIGH_RATE_TYPE ? `LRDS_OUT_CODE_MAX_HI : `LRDS_OUT_CODE_MAX_LO);
  endfunction

  wire logic [8:0] fb0_next = 9'(f.fb0_code) + `LRDS_FB_OFFSET;
  wire logic [8:0] fb1_next = 9'(f.fb1_code) + `LRDS_FB_OFFSET;
  // clockout factor is only selectable on the high-rate type
  wire logic [1:0] cko0_next = (HIGH_RATE_TYPE && f.cko0_bit) ? `LRDS_CKO_FACTOR_FULL
                                                              : `LRDS_CKO_FACTOR_HALF;
  wire logic [1:0] cko1_next = (HIGH_RATE_TYPE && f.cko1_bit) ? `LRDS_CKO_FACTOR_FULL
                                                              : `LRDS_CKO_FACTOR_HALF;
  wire logic       error_next = !out_ok(f.tx_code) || !out_ok(f.rx_code)
                             || !fb_ok(fb0_next) || !fb_ok(fb1_next)
                             || (ref_value(f.ref0_code) == 3'h0)
                             || (ref_value(f.ref1_code) == 3'h0);

  // registered decode keeps the data outputs glitch free
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      f.tx_ratio      <= 6'h01;
      f.rx_ratio      <= 6'h01;
      f.fb0_value     <= 9'h010;
      f.fb1_value     <= 9'h010;
      f.ref0_value    <= 3'h1;
      f.ref1_value    <= 3'h1;
      f.cko0_factor   <= `LRDS_CKO_FACTOR_HALF;
      f.cko1_factor   <= `LRDS_CKO_FACTOR_HALF;
      f.setting_error <= 1'b0;
    end
    else
    begin
      // [RULE8] output divider decode
      f.tx_ratio      <= out_ratio(f.tx_code);
      f.rx_ratio      <= out_ratio(f.rx_code);
      // [RULE14] feedback minus two
      f.fb0_value     <= fb0_next;
      f.fb1_value     <= fb1_next;
      // [RULE15] reference code table
      f.ref0_value    <= ref_value(f.ref0_code);
      f.ref1_value    <= ref_value(f.ref1_code);
      // [RULE12] fixed factor on low type
      f.cko0_factor   <= cko0_next;
      f.cko1_factor   <= cko1_next;
      f.setting_error <= error_next;
    end
  end

  property p_fb_minus_two;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> f.fb0_value == 9'($past(f.fb0_code)) + 9'h002;
  endproperty
  a_fb_minus_two: assert property (p_fb_minus_two) else $error("feedback value not code plus two"); // [RULE14]

  property p_ref_div1;
    @(posedge clk) disable iff (!reset_n)
    (f.ref1_code == 5'h10) |=> (f.ref1_value == 3'h1);
  endproperty
  a_ref_div1: assert property (p_ref_div1) else $error("reference code 16 not divide-by-1"); // [RULE15]

  property p_tx_div16;
    @(posedge clk) disable iff (!reset_n)
    (f.tx_code == 3'h4) |=> (f.tx_ratio == 6'h10);
  endproperty
  a_tx_div16: assert property (p_tx_div16) else $error("tx code 4 not divide-by-16"); // [RULE8]

  property p_shared_encoding;
    @(posedge clk) disable iff (!reset_n)
    (f.tx_code == f.rx_code) |=> (f.tx_ratio == f.rx_ratio);
  endproperty
  a_shared_encoding: assert property (p_shared_encoding) else $error("tx and rx encodings differ"); // [RULE7]

  property p_low_type_factor;
    @(posedge clk) disable iff (!reset_n)
    HIGH_RATE_TYPE || (f.cko0_factor == 2'h2 && f.cko1_factor == 2'h2);
  endproperty
  a_low_type_factor: assert property (p_low_type_factor) else $error("low type factor not 2"); // [RULE12]

endmodule

// ==== design/lrds_fields_if.sv ====
// raw divider fields and their decoded values between storage and decoder
interface lrds_fields_if;
  logic [2:0] tx_code;
  logic [2:0] rx_code;
  logic [7:0] fb0_code;
  logic [7:0] fb1_code;
  logic [4:0] ref0_code;
  logic [4:0] ref1_code;
  logic       cko0_bit;
  logic       cko1_bit;
  logic [5:0] tx_ratio;
  logic [5:0] rx_ratio;
  logic [8:0] fb0_value;
  logic [8:0] fb1_value;
  logic [2:0] ref0_value;
  logic [2:0] ref1_value;
  logic [1:0] cko0_factor;
  logic [1:0] cko1_factor;
  logic       setting_error;

  modport owner (
    output tx_code, rx_code, fb0_code, fb1_code, ref0_code, ref1_code, cko0_bit, cko1_bit,
    input  tx_ratio, rx_ratio, fb0_value, fb1_value, ref0_value, ref1_value,
    input  cko0_factor, cko1_factor, setting_error
  );
  modport decoder (
    input  tx_code, rx_code, fb0_code, fb1_code, ref0_code, ref1_code, cko0_bit, cko1_bit,
    output tx_ratio, rx_ratio, fb0_value, fb1_value, ref0_value, ref1_value,
    output cko0_factor, cko1_factor, setting_error
  );
endinterface

// ==== design/lrds_pkg.sv ====
// types shared by the line-rate divider block
package lrds_pkg;
  typedef enum logic {LRDS_SPACE_COMMON, LRDS_SPACE_CHANNEL} lrds_space_t;
  typedef enum logic [0:0] {LRDS_IDLE, LRDS_ANSWER} lrds_port_state_t;
endpackage

// ==== tb/lrds_host_model.sv ====
// host controller model that drives configuration-port accesses one at a time
module lrds_host_model (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // request side of the configuration port
  output logic                        cfg_en,
  output logic                        cfg_we,
  output lrds_pkg::lrds_space_t       cfg_space,
  output logic [7:0]                  cfg_addr,
  output logic [15:0]                 cfg_wdata,
  // answer side
  input  wire logic [15:0]            cfg_rdata,
  input  wire logic                   cfg_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // quiet bus at time zero
  initial
  begin
    cfg_en    = 1'b0;
    cfg_we    = 1'b0;
    cfg_space = lrds_pkg::LRDS_SPACE_COMMON;
    cfg_addr  = 8'h00;
    cfg_wdata = 16'h0000;
  end

  // single outstanding access
  // request held through the edge that samples ready; the released address and write data are inverted
  task automatic access(input logic we, input lrds_pkg::lrds_space_t sp, input logic [7:0] a,
                        input logic [15:0] wd, output logic [15:0] rd, output bit ok);
    int n;
    ok = 1'b0;
    rd = 16'h0000;
    @(negedge clk);
    cfg_en    = 1'b1;
    cfg_we    = we;
    cfg_space = sp;
    cfg_addr  = a;
    cfg_wdata = wd;
    for (n = 0; n < 8 && !ok; n++)
    begin
      @(negedge clk);
      if (cfg_ready === 1'b1)
      begin
        ok = 1'b1;
        rd = cfg_rdata;
      end
    end
    if (ok)
      @(posedge clk);
    @(negedge clk);
    cfg_en    = 1'b0;
    cfg_addr  = ~cfg_addr;
    cfg_wdata = ~cfg_wdata;
  endtask

  // read, modify, write
  // only masked bits change, so packed neighbours survive
  task automatic rmw(input lrds_pkg::lrds_space_t sp, input logic [7:0] a,
                     input logic [15:0] mask, input logic [15:0] val,
                     output logic [15:0] old, output bit ok);
    logic [15:0] dummy;
    bit          ok_rd;
    access(1'b0, sp, a, 16'h0000, old, ok_rd);
    access(1'b1, sp, a, (old & ~mask) | (val & mask), dummy, ok);
    ok = ok & ok_rd;
  endtask
endmodule

// ==== tb/tb_line_rate_divider_switching.sv ====
// self-checking bench for the line-rate divider configuration port
`include "lrds_defs.svh"

module tb_line_rate_divider_switching;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  clk;
  logic                  reset_n;
  logic                  cfg_en;
  logic                  cfg_we;
  lrds_pkg::lrds_space_t cfg_space;
  logic [7:0]            cfg_addr;
  logic [15:0]           cfg_wdata;
  logic [15:0]           cfg_rdata;
  logic                  cfg_ready;
  logic [5:0]            tx_div, rx_div, s_tx, s_rx;
  logic [8:0]            fb0, fb1, s_fb0;
  logic [2:0]            ref0, ref1, s_ref0;
  logic [1:0]            cko0, cko1, s_cko0;
  logic                  err, s_err;
  logic [2:0]            tx_c, rx_c;
  logic [7:0]            fb0_c, fb1_c;
  logic [4:0]            ref0_c, ref1_c;
  logic                  cko0_b, cko1_b;
  logic [15:0]           rd;
  bit                    ok;
  int                    i;
  int                    n_mismatch = 0;
  int                    check_count = 0;
  int                    cycles = 0;
  localparam lrds_pkg::lrds_space_t CH = lrds_pkg::LRDS_SPACE_CHANNEL;
  localparam lrds_pkg::lrds_space_t CO = lrds_pkg::LRDS_SPACE_COMMON;
  // controller-side words and reference frequency, values arbitrary
  localparam logic [7:0] PWR_ADDR = 8'h21, CAL_ADDR = 8'h22, EQ_ADDR = 8'h23;
  localparam int         F_IN = 100, SD_W = 8, SD_DATA = 256;
  logic [7:0]            ra [9] = '{8'h14, 8'h94, 8'h18, 8'h98, 8'h0E, 8'h8E, 8'h08, 8'h70, 8'h63};
  logic [15:0]           rv [9] = '{16'h000E, 16'h000E, 16'h0800, 16'h0800, 16'h0001,
                                    16'h0001, 16'h0000, 16'h0000, 16'h0000};
  logic [7:0]            fbk [4] = '{8'h0D, 8'h0E, 8'h9E, 8'h9F};

  lrds_host_model lrds_host_model_inst (.clk(clk), .reset_n(reset_n), .cfg_en(cfg_en),
    .cfg_we(cfg_we), .cfg_space(cfg_space), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ready(cfg_ready));

  lrds_config_port lrds_config_port_inst (.clk(clk), .reset_n(reset_n), .cfg_en(cfg_en),
    .cfg_we(cfg_we), .cfg_space(cfg_space), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_ready(cfg_ready), .tx_output_divider(tx_div),
    .rx_output_divider(rx_div), .ring_pll0_feedback_divider(fb0),
    .ring_pll1_feedback_divider(fb1), .ring_pll0_reference_divider(ref0),
    .ring_pll1_reference_divider(ref1), .ring_pll0_clockout_rate(cko0),
    .ring_pll1_clockout_rate(cko1), .divider_setting_error(err));

  // static low-rate build shares the bus; its divider fields must never move
  lrds_config_port #(.DYNAMIC_RATE_EN(1'b0), .HIGH_RATE_TYPE(1'b0))
    lrds_config_port_static_inst (.clk(clk),
    .reset_n(reset_n), .cfg_en(cfg_en), .cfg_we(cfg_we), .cfg_space(cfg_space),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(), .cfg_ready(),
    .tx_output_divider(s_tx), .rx_output_divider(s_rx), .ring_pll0_feedback_divider(s_fb0),
    .ring_pll1_feedback_divider(), .ring_pll0_reference_divider(s_ref0),
    .ring_pll1_reference_divider(), .ring_pll0_clockout_rate(s_cko0), .ring_pll1_clockout_rate(),
    .divider_setting_error(s_err));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end

  // expected decode of the stored codes
  function automatic logic [5:0] out_ratio(input logic [2:0] c);
    return (c <= 3'h5) ? (6'h01 << c) : 6'h00;
  endfunction

  function automatic logic [2:0] ref_val(input logic [4:0] c);
    return (c == 5'h10) ? 3'h1 : (c <= 5'h02) ? 3'(c + 5'h02) : 3'h0;
  endfunction

  function automatic logic exp_err();
    return out_ratio(tx_c) == 0 || out_ratio(rx_c) == 0 || fb0_c < 8'h0E || fb0_c > 8'h9E ||
           fb1_c < 8'h0E || fb1_c > 8'h9E || ref_val(ref0_c) == 0 || ref_val(ref1_c) == 0;
  endfunction

  // pll output from reference, dividers and factor; line rate
  // fraction kept at one: sigma-delta data equals two to its width
  function automatic logic [31:0] rate(input logic [8:0] n, input logic [2:0] m,
                                       input logic [1:0] r, input logic [5:0] d);
    return 2 * ((F_IN * n * SD_DATA) >> SD_W) / (m * r * d);
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // decoded outputs against the shadow codes, static build against its reset decode
  task automatic check_outputs();
    chk(16'(tx_div), 16'(out_ratio(tx_c)));
    chk(16'(rx_div), 16'(out_ratio(rx_c)));
    chk(16'(fb0), 16'(fb0_c) + 16'h0002);
    chk(16'(fb1), 16'(fb1_c) + 16'h0002);
    chk(16'(ref0), 16'(ref_val(ref0_c)));
    chk(16'(ref1), 16'(ref_val(ref1_c)));
    chk(16'(cko0), cko0_b ? 16'h0001 : 16'h0002);
    chk(16'(cko1), cko1_b ? 16'h0001 : 16'h0002);
    chk(16'(err), 16'(exp_err()));
    chk({s_tx, s_rx, s_ref0, 1'b0}, 16'h0412);
    chk({4'h0, s_cko0, s_fb0, s_err}, 16'h0820);
  endtask

  // read-modify-write one word, read it back, track divider codes
  task automatic put(input lrds_pkg::lrds_space_t sp, input logic [7:0] a,
                     input logic [15:0] mask, input logic [15:0] val);
    logic [15:0] old;
    logic [15:0] exp;
    logic [15:0] back;
    bit          good;
    lrds_host_model_inst.rmw(sp, a, mask, val, old, good);
    chk(16'(good), 16'h0001);
    lrds_host_model_inst.access(1'b0, sp, a, 16'h0000, back, good);
    exp = (old & ~mask) | (val & mask);
    chk(back, exp);
    if (sp == CH)
    begin
      if (a == `LRDS_ADDR_TX_DIV) tx_c = exp[10:8];
      if (a == `LRDS_ADDR_RX_DIV) rx_c = exp[2:0];
    end
    else
    begin
      if (a == `LRDS_ADDR_PLL0_FB) fb0_c = exp[7:0];
      if (a == `LRDS_ADDR_PLL1_FB) fb1_c = exp[7:0];
      if (a == `LRDS_ADDR_PLL0_REF) ref0_c = exp[11:7];
      if (a == `LRDS_ADDR_PLL1_REF) ref1_c = exp[11:7];
      if (a == `LRDS_ADDR_PLL0_CKO) cko0_b = exp[0];
      if (a == `LRDS_ADDR_PLL1_CKO) cko1_b = exp[0];
    end
    check_outputs();
  endtask

  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence: reset words, every out, reference and clockout code, edge and random feedback codes, then random whole-word traffic
  initial
  begin
    void'($urandom(32'hf1e61ac3));
    reset_n = 1'b0;
    {tx_c, rx_c, fb0_c, fb1_c} = {3'h0, 3'h0, 8'h0E, 8'h0E};
    {ref0_c, ref1_c, cko0_b, cko1_b} = {5'h10, 5'h10, 1'b1, 1'b1};
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    check_outputs();
    for (i = 0; i < 9; i++)
    begin
      lrds_host_model_inst.access(1'b0, lrds_pkg::lrds_space_t'(i > 6), ra[i], 16'h0000, rd, ok);
      chk(rd, rv[i]);
    end
    for (i = 0; i < 8; i++)
    begin
      put(CH, `LRDS_ADDR_TX_DIV, `LRDS_MASK_TX_DIV,
          {5'($urandom), 3'(i), 8'($urandom)});
      put(CH, `LRDS_ADDR_RX_DIV, `LRDS_MASK_RX_DIV,
          {13'($urandom), 3'(i)});
    end
    for (i = 0; i < 32; i++)
    begin
      put(CO, `LRDS_ADDR_PLL0_REF, `LRDS_MASK_REF,
          {4'($urandom), 5'(i), 7'($urandom)});
      put(CO, `LRDS_ADDR_PLL1_REF, `LRDS_MASK_REF,
          {4'($urandom), 5'(31 - i), 7'($urandom)});
    end
    for (i = 0; i < 24; i++)
    begin
      put(CO, `LRDS_ADDR_PLL0_FB, `LRDS_MASK_FB,
          {8'($urandom), (i < 4) ? fbk[i] : 8'($urandom)});
      put(CO, `LRDS_ADDR_PLL1_FB, `LRDS_MASK_FB,
          {8'($urandom), (i < 4) ? fbk[3 - i] : 8'($urandom)});
    end
    for (i = 0; i < 4; i++)
    begin
      put(CO, `LRDS_ADDR_PLL0_CKO, `LRDS_MASK_CKO,
          {15'($urandom), 1'(i)});
      put(CO, `LRDS_ADDR_PLL1_CKO, `LRDS_MASK_CKO,
          {15'($urandom), 1'(i + 1)});
    end
    // traffic drained: park tx, calibrate, retune pll0, wake, restart equalizer
    put(CH, PWR_ADDR, 16'h0003, 16'h0003);
    put(CH, CAL_ADDR, 16'hFFFF, 16'h0800);
    put(CO, `LRDS_ADDR_PLL0_FB, `LRDS_MASK_FB, 16'h0062);
    put(CO, `LRDS_ADDR_PLL0_REF, `LRDS_MASK_REF, 16'h0800);
    put(CO, `LRDS_ADDR_PLL0_CKO, `LRDS_MASK_CKO, 16'h0001);
    put(CH, `LRDS_ADDR_TX_DIV, `LRDS_MASK_TX_DIV, 16'h0100);
    put(CH, PWR_ADDR, 16'h0003, 16'h0000);
    put(CH, EQ_ADDR, 16'h0001, 16'h0001);
    put(CH, EQ_ADDR, 16'h0001, 16'h0000);
    chk(16'(rate(fb0, ref0, cko0, tx_div)), 16'(rate(9'h064, 3'h1, 2'h1, 6'h02)));
    for (i = 0; i < 150; i++)
    begin
      put(lrds_pkg::lrds_space_t'($urandom_range(1, 0)), 8'($urandom), 16'hFFFF,
          16'($urandom));
    end
    end_sim();
  end
endmodule
